// *** logic/uiw_pkg.sv ***
// Purpose: constants and carrier types for the upstream window traffic class map
// Assumes: byte addresses on the register bus, one aligned 32-bit word per register
// Notes:   window offsets and reset values are shared by design and bench
package uiw_pkg;

    // ****************************************
    // register bus geometry
    // ****************************************
    localparam int          APB_AW      = 8;
    localparam int          APB_DW      = 32;
    localparam int          APB_SW      = APB_DW / 8;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [7:0]  OFS_CAP     = 8'h00;
    localparam logic [7:0]  OFS_GCTRL   = 8'h04;
    localparam logic [7:0]  OFS_W0_CTRL = 8'h08;
    localparam logic [7:0]  OFS_W0_BASE = 8'h0c;
    localparam logic [7:0]  OFS_W0_LIM  = 8'h10;
    localparam logic [7:0]  OFS_W1_CTRL = 8'h14;
    localparam logic [7:0]  OFS_W1_BASE = 8'h18;
    localparam logic [7:0]  OFS_W1_LIM  = 8'h1c;

    // ****************************************
    // windows and fields
    // ****************************************
    localparam int          WIN_NUM     = 2;
    localparam int          WIN_IDX_W   = 1;
    localparam int          TC_W        = 3;
    localparam int          CTRL_EN_BIT = 0;
    localparam int          CTRL_TC_LSB = 1;
    localparam int          CTRL_TC_MSB = 3;
    localparam int          GCTRL_EN_BIT = 0;
    localparam logic [3:0]  WIN_COUNT   = 4'h4;
    localparam logic [TC_W-1:0] TC_ZERO = 3'h0;

    localparam logic [7:0]  WIN_CTRL_OFS [WIN_NUM] = '{OFS_W0_CTRL, OFS_W1_CTRL};
    localparam logic [7:0]  WIN_BASE_OFS [WIN_NUM] = '{OFS_W0_BASE, OFS_W1_BASE};
    localparam logic [7:0]  WIN_LIM_OFS  [WIN_NUM] = '{OFS_W0_LIM,  OFS_W1_LIM};

    // ****************************************
    // reset values
    // ****************************************
    localparam logic        EN_RST      = 1'b0;
    localparam logic [TC_W-1:0] TC_RST  = 3'h0;
    localparam logic [31:0] ADDR_RST    = 32'h0000_0000;
    localparam logic [31:0] DATA_ZERO   = 32'h0000_0000;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic                 valid;
        logic [31:0]          addr;
    } uiw_req_t;

    typedef struct packed {
        logic                 valid;
        logic [31:0]          addr;
        logic [TC_W-1:0]      tc;
        logic                 hit;
        logic [WIN_IDX_W-1:0] win;
    } uiw_tag_t;

endpackage

// *** logic/uiw_top.sv ***
// Purpose: register bank and address matcher assigning traffic classes upstream
// Assumes: APB slave, inputs synchronous to clock, synchronous active-low reset
// Notes:   tag result appears one clock after the request, no back-pressure
//
// Notes on behaviour
// RULE1: window control registers at 08h, 14h, reset zero
// RULE2: control bits 15:4 read as zero
// RULE3: control bits 3:1 select window traffic class
// RULE4: class selector resets to 000b
// RULE5: disabled window never changes traffic class
// RULE6: enabled window tags matching addresses with class
// RULE7: base registers at 0Ch, 18h, reset zero
// RULE8: limit registers at 10h, 1Ch, upper bound
// RULE9: base and limit keep 32 bits always
// RULE10: base is the lower bound of window
// RULE11: global enable off forces class zero
// RULE12: four windows reported, two covered here
// RULE13: inside means base <= address <= limit
// RULE14: no match gives zero; lowest window wins
module uiw_top
    import uiw_pkg::*;
(
    input  wire logic                  clock,    // 200 MHz system clock
    input  wire logic                  nrst,     // synchronous reset, active low
    input  wire logic                  psel,     // apb select
    input  wire logic                  penable,  // apb access phase
    input  wire logic                  pwrite,   // apb direction, high for write
    input  wire logic [uiw_pkg::APB_AW-1:0] paddr,  // apb byte address
    input  wire logic [uiw_pkg::APB_DW-1:0] pwdata, // apb write data
    input  wire logic [uiw_pkg::APB_SW-1:0] pstrb,  // apb byte strobes
    output logic      [uiw_pkg::APB_DW-1:0] prdata, // apb read data
    output logic                       pready,   // apb transfer complete
    output logic                       pslverr,  // apb unmapped address
    input  wire uiw_pkg::uiw_req_t     up_req,   // upstream request address
    output uiw_pkg::uiw_tag_t          up_tag    // tagged upstream request
);
    import uiw_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    logic                  window_map_enable          [WIN_NUM];
    logic [TC_W-1:0]       traffic_class_select       [WIN_NUM];
    logic [31:0]           win_base                   [WIN_NUM];
    logic [31:0]           win_limit                  [WIN_NUM];
    logic                  upstream_tc_mapping_enable;

    logic                  setup;
    logic                  wr_commit;
    logic [APB_DW-1:0]     rd_data;
    logic                  rd_hit;
    logic [APB_DW-1:0]     wr_data;
    uiw_tag_t              next_tag;

    // one select per register, shared by the read mux and the write enables
    logic                  sel_cap;
    logic                  sel_gctrl;
    logic                  sel_ctrl                   [WIN_NUM];
    logic                  sel_base                   [WIN_NUM];
    logic                  sel_lim                    [WIN_NUM];
    logic                  win_match                  [WIN_NUM];

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] strb_merge(
        input logic [31:0]       old_val,
        input logic [31:0]       new_val,
        input logic [APB_SW-1:0] strb
    );
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < APB_SW; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic in_window(
        input logic [31:0] addr,
        input logic [31:0] base,
        input logic [31:0] limit
    );
        // both bounds inclusive; base above limit gives an empty window
        return (addr >= base) && (addr <= limit); // RULE10 RULE13
    endfunction

    function automatic logic ofs_match(
        input logic [APB_AW-1:0] addr,
        input logic [7:0]        ofs
    );
        // full byte compare: misaligned addresses stay unmapped
        return addr == ofs;
    endfunction

    // ****************************************
    // bus handshake
    // ****************************************
    assign setup     = psel && !penable;
    // pready is only high in the access phase, so this is the completing edge
    assign wr_commit = psel && penable && pready && pwrite && !pslverr;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pready <= 1'b0;
        end else begin
            // fixed single access cycle, no wait states
            pready <= setup;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !rd_hit;
        end else if (pready) begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            prdata <= DATA_ZERO;
        end else if (setup) begin
            prdata <= pwrite ? DATA_ZERO : rd_data;
        end else if (pready) begin
            prdata <= DATA_ZERO;
        end
    end

    // ****************************************
    // address decode
    // ****************************************
    always_comb begin
        sel_cap   = ofs_match(paddr, OFS_CAP);
        sel_gctrl = ofs_match(paddr, OFS_GCTRL);
        for (int i = 0; i < WIN_NUM; i++) begin
            sel_ctrl[i] = ofs_match(paddr, WIN_CTRL_OFS[i]); // RULE1
            sel_base[i] = ofs_match(paddr, WIN_BASE_OFS[i]); // RULE7
            sel_lim[i]  = ofs_match(paddr, WIN_LIM_OFS[i]); // RULE8
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // an address that selects nothing leaves rd_hit low and so reports an error
    always_comb begin
        rd_data = DATA_ZERO;
        rd_hit  = 1'b0;
        if (sel_cap) begin
            rd_hit  = 1'b1;
            rd_data = {28'h0000000, WIN_COUNT}; // RULE12
        end
        if (sel_gctrl) begin
            rd_hit  = 1'b1;
            rd_data = {31'h00000000, upstream_tc_mapping_enable};
        end
        for (int i = 0; i < WIN_NUM; i++) begin
            if (sel_ctrl[i]) begin
                rd_hit  = 1'b1;
                rd_data = {28'h0000000, traffic_class_select[i], window_map_enable[i]}; // RULE2
            end
            if (sel_base[i]) begin
                rd_hit  = 1'b1;
                rd_data = win_base[i];
            end
            if (sel_lim[i]) begin
                rd_hit  = 1'b1;
                rd_data = win_limit[i];
            end
        end
    end

    // strobes merge into the present contents; unwritten lanes keep their value
    assign wr_data = strb_merge(rd_data, pwdata, pstrb);

    // ****************************************
    // global mapping enable
    // ****************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            upstream_tc_mapping_enable <= EN_RST;
        end else if (wr_commit && sel_gctrl) begin
            // only the enable is stored; the arbiter bits are not built here
            upstream_tc_mapping_enable <= wr_data[GCTRL_EN_BIT];
        end
    end

    // ****************************************
    // window enable bits
    // ****************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < WIN_NUM; i++) begin
                window_map_enable[i] <= EN_RST; // RULE1 RULE5
            end
        end else begin
            for (int i = 0; i < WIN_NUM; i++) begin
                if (wr_commit && sel_ctrl[i]) begin // RULE1
                    window_map_enable[i] <= wr_data[CTRL_EN_BIT];
                end
            end
        end
    end

    // ****************************************
    // window class selectors
    // ****************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < WIN_NUM; i++) begin
                traffic_class_select[i] <= TC_RST; // RULE4
            end
        end else begin
            for (int i = 0; i < WIN_NUM; i++) begin
                if (wr_commit && sel_ctrl[i]) begin // RULE1
                    traffic_class_select[i] <= wr_data[CTRL_TC_MSB:CTRL_TC_LSB]; // RULE3
                end
            end
        end
    end

    // ****************************************
    // window base registers
    // ****************************************
    // kept regardless of the enable so software may use them as scratch
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < WIN_NUM; i++) begin
                win_base[i] <= ADDR_RST; // RULE7
            end
        end else begin
            for (int i = 0; i < WIN_NUM; i++) begin
                if (wr_commit && sel_base[i]) begin // RULE7
                    win_base[i] <= wr_data; // RULE9
                end
            end
        end
    end

    // ****************************************
    // window limit registers
    // ****************************************
    always_ff @(posedge clock) begin
        if (!nrst) begin
            for (int i = 0; i < WIN_NUM; i++) begin
                win_limit[i] <= ADDR_RST;
            end
        end else begin
            for (int i = 0; i < WIN_NUM; i++) begin
                if (wr_commit && sel_lim[i]) begin // RULE8
                    win_limit[i] <= wr_data; // RULE9
                end
            end
        end
    end

    // ****************************************
    // traffic class match
    // ****************************************
    // idle cycles match nothing, so a tag without a request claims no window
    always_comb begin
        for (int i = 0; i < WIN_NUM; i++) begin
            win_match[i] = up_req.valid && window_map_enable[i]
                           && in_window(up_req.addr, win_base[i], win_limit[i]); // RULE5
        end
    end

    always_comb begin
        next_tag       = '0;
        next_tag.valid = up_req.valid;
        next_tag.addr  = up_req.addr;
        next_tag.tc    = TC_ZERO; // RULE14
        // walk downward so the lowest matching window is applied last
        for (int i = WIN_NUM - 1; i >= 0; i--) begin
            if (win_match[i]) begin
                next_tag.tc  = traffic_class_select[i]; // RULE6 RULE14
                next_tag.hit = 1'b1;
                next_tag.win = WIN_IDX_W'(i);
            end
        end
        // without the global enable every request stays in class zero
        if (!upstream_tc_mapping_enable) begin
            next_tag.tc  = TC_ZERO; // RULE11
            next_tag.hit = 1'b0;
            next_tag.win = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            up_tag <= '0;
        end else begin
            up_tag <= next_tag;
        end
    end

endmodule

// *** tb/uiw_top_monitor.sv ***
// Purpose: port checks for the window class map
// Assumes: zero-wait apb slave, tag one clock after request
// Notes:   bound to every uiw_top
module uiw_top_monitor
    import uiw_pkg::*;
(
    input wire logic              clock,   // clock
    input wire logic              nrst,    // reset
    input wire logic              psel,    // select
    input wire logic              penable, // access
    input wire logic              pwrite,  // dir
    input wire logic [APB_AW-1:0] paddr,   // addr
    input wire logic [APB_DW-1:0] pwdata,  // wdata
    input wire logic [APB_SW-1:0] pstrb,   // strobes
    input wire logic [APB_DW-1:0] prdata,  // rdata
    input wire logic              pready,  // ready
    input wire logic              pslverr, // error
    input wire uiw_req_t          up_req,  // request
    input wire uiw_tag_t          up_tag   // tag
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****
    // checks
    // ****
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("late ready");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("long ready");
    property p_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_quiet: assert property (p_quiet) else $error("stray data");
    property p_resv; pready && (paddr == OFS_W0_CTRL || paddr == OFS_W1_CTRL)
        |-> prdata[31:4] == 28'h0; endproperty
    a_resv: assert property (p_resv) else $error("upper bits set");
    property p_unmap; pready && paddr >= 8'h20 |-> pslverr && prdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("no error");
    property p_pass; up_req.valid |=> up_tag.valid && up_tag.addr == $past(up_req.addr);
    endproperty
    a_pass: assert property (p_pass) else $error("tag lost");
    property p_notc; !up_tag.hit |-> up_tag.tc == 3'h0 && up_tag.win == 1'b0; endproperty
    a_notc: assert property (p_notc) else $error("class without hit");
    property p_nowin; !up_tag.valid |-> !up_tag.hit; endproperty
    a_nowin: assert property (p_nowin) else $error("idle hit");
    c_hit: cover property (up_tag.hit && up_tag.win == 1'b1);
    c_err: cover property (pready && pslverr);
    c_wr: cover property (pready && pwrite);
endmodule

bind uiw_top uiw_top_monitor u_mon (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .up_req, .up_tag);

// *** tb/uiw_up_src.sv ***
// Purpose: upstream requester in place of secondary bus masters
// Assumes: one request per clock, no back-pressure
// Notes:   released address shows the inverse of the last value
module uiw_up_src
    import uiw_pkg::*;
(
    input  wire logic clock,  // clock
    output uiw_req_t  up_req  // request
);
    timeunit 1ns;
    timeprecision 1ps;
    initial up_req = '0;
    task automatic send(input logic [31:0] a);
        up_req <= '{valid: 1'b1, addr: a};
        @(posedge clock);
    endtask
    // stale address would hide a missing valid check
    task automatic idle();
        up_req <= '{valid: 1'b0, addr: ~up_req.addr};
    endtask
endmodule

// *** tb/uiw_top_tb.sv ***
// Purpose: register and mapping tests for the window class map
// Assumes: apb tasks, requester model
// Notes:   expected values written out per case
module uiw_top_tb;
    import uiw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0]  pstrb = 4'h0;
    uiw_req_t    up_req;
    uiw_tag_t    up_tag;
    int          errors = 0, checks = 0, cycles = 0;
    always #2.5 clock = ~clock;
    uiw_top DUT (.clock, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .up_req, .up_tag);
    uiw_up_src u_src (.clock, .up_req);
    // ****
    // tasks
    // ****
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic err);
        apb(1'b0, a, 32'h0, 4'h0);
        check({7'h00, rerr, rdat}, {7'h00, err, e});
    endtask
    task automatic probe(input logic [31:0] a, input logic [2:0] t, input logic h,
                         input logic w);
        u_src.send(a);
        // tag is launched at this edge; look once it has settled
        @(negedge clock);
        check(up_tag, {1'b1, a, t, h, w});
        @(posedge clock);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            tally_and_finish;
        end
    end
    // ****
    // sequence
    // ****
    initial begin
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        foreach (WIN_CTRL_OFS[i]) begin
            rd(WIN_CTRL_OFS[i], 32'h0, 1'b0);
            rd(WIN_BASE_OFS[i], 32'h0, 1'b0);
            rd(WIN_LIM_OFS[i], 32'h0, 1'b0);
            wr(WIN_BASE_OFS[i], 32'ha5c3_3c5a);
            rd(WIN_BASE_OFS[i], 32'ha5c3_3c5a, 1'b0);
            wr(WIN_LIM_OFS[i], 32'h5a3c_c3a5);
            rd(WIN_LIM_OFS[i], 32'h5a3c_c3a5, 1'b0);
            wr(WIN_CTRL_OFS[i], 32'hffff_ffff);
            rd(WIN_CTRL_OFS[i], 32'h0000_000f, 1'b0);
        end
        apb(1'b1, OFS_W1_LIM, 32'hffff_ffff, 4'h2);
        rd(OFS_W1_LIM, 32'h5a3c_ffa5, 1'b0);
        rd(8'h20, 32'h0, 1'b1);
        rd(OFS_CAP, 32'h0000_0004, 1'b0);
        wr(OFS_W0_BASE, 32'h0000_1000);
        wr(OFS_W0_LIM, 32'h0000_1fff);
        wr(OFS_W1_BASE, 32'h0000_1800);
        wr(OFS_W1_LIM, 32'h0000_2fff);
        wr(OFS_W1_CTRL, 32'h0000_0007);
        probe(32'h0000_1000, 3'h0, 1'b0, 1'b0);
        wr(OFS_GCTRL, 32'h0000_0001);
        for (int t = 0; t < 8; t++) begin
            wr(OFS_W0_CTRL, {28'h0, t[2:0], 1'b1});
            probe(32'h0000_1000, t[2:0], 1'b1, 1'b0);
        end
        probe(32'h0000_0fff, 3'h0, 1'b0, 1'b0);
        probe(32'h0000_1fff, 3'h7, 1'b1, 1'b0);
        probe(32'h0000_1800, 3'h7, 1'b1, 1'b0);
        probe(32'h0000_2000, 3'h3, 1'b1, 1'b1);
        probe(32'h0000_3000, 3'h0, 1'b0, 1'b0);
        u_src.idle();
        wr(OFS_W0_CTRL, 32'h0000_000e);
        probe(32'h0000_1800, 3'h3, 1'b1, 1'b1);
        u_src.idle();
        wr(OFS_GCTRL, 32'h0000_0000);
        probe(32'h0000_2000, 3'h0, 1'b0, 1'b0);
        // mid-run reset with the requester idle
        u_src.idle();
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd(OFS_W0_CTRL, 32'h0, 1'b0);
        rd(OFS_W1_BASE, 32'h0, 1'b0);
        rd(OFS_W0_LIM, 32'h0, 1'b0);
        tally_and_finish;
    end
endmodule
